// *** rtl/isv_defs.vh ***
// Constants for the instruction-set variant decoder
// What this block does
// RULE1 - Same-register autostep dest: stepped or initial source
// RULE2 - Same for deferred autostep destination
// RULE3 - Stored PC is instruction address plus 4 or 2
// RULE4 - Autoincrement jump target: stepped or initial register
// RULE5 - Register-mode jump traps to vector 10 or 4
// RULE6 - Byte swap keeps or clears overflow flag
// RULE7 - Register window: valid, CPU timeout, or both timeout
// RULE8 - Optional instruction groups enabled per variant
// RULE9 - Long reset 70 ms, init 20 ms, power-fail deferred
// RULE10 - Abortable reset: power-fail ends it, minimum init 1 us
// RULE11 - Short reset 22 ms, min 300 ns, fetch fail fatal
// RULE12 - Every option fixed by an elaboration-time parameter; the CTRL register can also disable optional groups at run time
`ifndef ISV_DEFS_VH
`define ISV_DEFS_VH

// Register byte offsets
`define ISV_REG_CTRL 5'h00
`define ISV_REG_STATUS 5'h04
`define ISV_REG_MASK 5'h08
`define ISV_REG_STATE 5'h0c
`define ISV_REG_CONFIG 5'h10
`define ISV_CTRL_RESET 13'h1fff

// Status and mask bit positions
`define ISV_EV_ILL_JUMP 0
`define ISV_EV_RSVD_OP 1
`define ISV_EV_WIN_TMO 2
`define ISV_EV_RST_DONE 3
`define ISV_EV_PF_TRAP 4
`define ISV_EV_PF_FATAL 5
`define ISV_EV_PF_ACK 6
`define ISV_EV_W 7

// Trap vectors (octal 10 and 4)
`define ISV_VEC_ILLEGAL 8'h08
`define ISV_VEC_BUSERR 8'h04

// Register window 177700..177717 octal
`define ISV_WIN_LO 16'hffc0
`define ISV_WIN_HI 16'hffcf

// Window modes and reset variants
`define ISV_WIN_VALID 2'h0
`define ISV_WIN_CPU_TMO 2'h1
`define ISV_WIN_ALL_TMO 2'h2
`define ISV_RST_LONG 2'h0
`define ISV_RST_ABORT 2'h1
`define ISV_RST_SHORT 2'h2

// Operand step size
`define ISV_STEP 16'h0002

// Timing: clock period and documented times, sized to the 24-bit counters
`define ISV_CLK_NS 24'h00000a
`define ISV_CYC_PER_MS 24'h0186a0
`define ISV_LONG_RST_MS 24'h000046
`define ISV_LONG_INIT_MS 24'h000014
`define ISV_SHORT_RST_MS 24'h000016
`define ISV_ABORT_MIN_NS 24'h0003e8
`define ISV_SHORT_MIN_NS 24'h00012c
`define ISV_ABORT_MIN_CYC ((`ISV_ABORT_MIN_NS + `ISV_CLK_NS - 24'h000001) / `ISV_CLK_NS)
`define ISV_SHORT_MIN_CYC ((`ISV_SHORT_MIN_NS + `ISV_CLK_NS - 24'h000001) / `ISV_CLK_NS)

`endif

// *** rtl/isv_reset_seq.v ***
// Bus-reset instruction sequencer with power-fail handling
`timescale 1ns/10ps
`include "isv_defs.vh"
module isv_reset_seq #(
    parameter [1:0] VARIANT = `ISV_RST_LONG,
    parameter [23:0] TOTAL_CYC = 24'd7000000,
    parameter [23:0] INIT_CYC = 24'd2000000,
    parameter [23:0] MIN_CYC = 24'd100
) (
    input wire clk_sys,
    input wire rst,
    input wire start,
    input wire pf_rise,
    output reg init,
    output reg busy,
    output reg done,
    output reg pf_trap,
    output reg pf_late
);
    reg [23:0] count;
    reg pf_hold;
    // Busy ends one cycle early: the top registers it once more
    wire at_end = (count == TOTAL_CYC - 24'd2);
    wire at_init_end = (count == INIT_CYC - 24'd1);
    wire min_met = (count >= MIN_CYC - 24'd1);

    // Sequencer: counts the instruction, ends early on power fail in the abort and short variants
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            count <= 24'h000000;
            init <= 1'b0;
            busy <= 1'b0;
            done <= 1'b0;
            pf_trap <= 1'b0;
            pf_late <= 1'b0;
            pf_hold <= 1'b0;
        end else begin
            done <= 1'b0;
            pf_trap <= 1'b0;
            pf_late <= 1'b0;
            if (!busy) begin
                if (start) begin
                    busy <= 1'b1;
                    init <= 1'b1;
                    count <= 24'h000000;
                    pf_hold <= 1'b0;
                end
            end else begin
                count <= count + 24'd1;
                if (pf_rise)
                    pf_hold <= 1'b1;
                if (VARIANT == `ISV_RST_LONG) begin
                    if (at_init_end)
                        init <= 1'b0; // see RULE9
                    if (at_end) begin
                        busy <= 1'b0;
                        done <= 1'b1;
                        pf_late <= pf_hold | pf_rise; // see RULE9
                    end
                end else if ((pf_rise | pf_hold) && min_met) begin
                    busy <= 1'b0; // see RULE10
                    init <= 1'b0;
                    done <= 1'b1;
                    pf_trap <= init; // see RULE10
                end else if (at_end) begin
                    busy <= 1'b0; // see RULE11
                    init <= 1'b0;
                    done <= 1'b1;
                end
            end
        end
    end
endmodule // isv_reset_seq

// *** rtl/isv_decoder.v ***
// Variant-aware decode and execute options with Wishbone status block
//
// Local design decisions: the Wishbone slave port and the register offsets.
`timescale 1ns/10ps
`include "isv_defs.vh"
module isv_decoder #(
    parameter [0:0] SAME_REG_STEPPED = 1'b1,
    parameter [0:0] DEF_REG_STEPPED = 1'b1,
    parameter [0:0] PC_STORE_PLUS4 = 1'b1,
    parameter [0:0] JUMP_AUTOINC_STEPPED = 1'b1,
    parameter [0:0] JUMP_REG_VEC4 = 1'b0,
    parameter [0:0] BYTE_SWAP_OP_CLEARS_V = 1'b0,
    parameter [1:0] WIN_MODE = `ISV_WIN_CPU_TMO,
    parameter [12:0] GROUP_EN = 13'h1fff,
    parameter [1:0] RST_VARIANT = `ISV_RST_LONG,
    parameter [23:0] LONG_RST_CYC = `ISV_LONG_RST_MS * `ISV_CYC_PER_MS,
    parameter [23:0] LONG_INIT_CYC = `ISV_LONG_INIT_MS * `ISV_CYC_PER_MS,
    parameter [23:0] SHORT_RST_CYC = `ISV_SHORT_RST_MS * `ISV_CYC_PER_MS
) (
    input wire clk_sys,
    input wire rst,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [4:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    input wire dec_valid,
    input wire [15:0] dec_instr,
    input wire [15:0] dec_pc,
    input wire [15:0] dec_reg,
    input wire acc_valid,
    input wire acc_console,
    input wire [15:0] acc_addr,
    input wire power_fail,
    output reg dec_done,
    output reg src_override,
    output reg [15:0] src_value,
    output reg pc_store,
    output reg [15:0] pc_store_value,
    output reg jump_valid,
    output reg [15:0] jump_pc,
    output reg trap_req,
    output reg [7:0] trap_vec,
    output reg v_clear,
    output reg acc_timeout,
    output reg bus_init,
    output reg reset_busy,
    output reg pf_ack,
    output reg pf_fatal,
    output reg irq
);
    // Step a register the way its addressing mode does
    function [15:0] stepped;
        input [15:0] val;
        input [2:0] mode;
        begin
            if (mode == 3'd4 || mode == 3'd5)
                stepped = val - `ISV_STEP;
            else
                stepped = val + `ISV_STEP;
        end
    endfunction

    // Address falls in the general-register window
    function in_window;
        input [15:0] a;
        begin
            in_window = (a >= `ISV_WIN_LO) && (a <= `ISV_WIN_HI);
        end
    endfunction

    // Reset cycle counts picked by variant, see RULE12
    localparam [23:0] SEQ_TOTAL = (RST_VARIANT == `ISV_RST_SHORT) ? SHORT_RST_CYC : LONG_RST_CYC;
    localparam [23:0] SEQ_INIT = (RST_VARIANT == `ISV_RST_LONG) ? LONG_INIT_CYC : SEQ_TOTAL;
    localparam [23:0] SEQ_MIN = (RST_VARIANT == `ISV_RST_SHORT) ?
        `ISV_SHORT_MIN_CYC : `ISV_ABORT_MIN_CYC;

    // Software registers
    reg [12:0] ctrl_groups;
    reg [`ISV_EV_W-1:0] status;
    reg [`ISV_EV_W-1:0] mask;
    reg [`ISV_EV_W-1:0] events;
    reg [7:0] last_vec;

    // Power-fail pin synchroniser and filtered level
    reg pf_s1, pf_s2, pf_s3, pf_level;
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pf_s1 <= 1'b0;
            pf_s2 <= 1'b0;
            pf_s3 <= 1'b0;
            pf_level <= 1'b0;
        end else begin
            pf_s1 <= power_fail;
            pf_s2 <= pf_s1;
            pf_s3 <= pf_s2;
            if (pf_s2 == pf_s3)
                pf_level <= pf_s3;
        end
    end
    wire pf_rise = pf_s2 & pf_s3 & ~pf_level;

    // Field split of the instruction word
    wire [2:0] s_mode = dec_instr[11:9];
    wire [2:0] s_reg = dec_instr[8:6];
    wire [2:0] d_mode = dec_instr[5:3];
    wire [2:0] d_reg = dec_instr[2:0];
    wire is_double = (dec_instr[14:12] != 3'd0) && (dec_instr[14:12] != 3'd7);
    wire is_jump = (dec_instr[15:6] == 10'h001);
    wire is_call = (dec_instr[15:9] == 7'h04);
    wire is_byte_swap_op = (dec_instr[15:6] == 10'h003);
    wire is_reset = (dec_instr == 16'h0005);

    // Optional group recognition, see RULE8
    wire [12:0] grp_hit;
    assign grp_hit[0] = (dec_instr[15:9] == 7'h3f);
    assign grp_hit[1] = (dec_instr[15:6] == 10'h034);
    assign grp_hit[2] = (dec_instr == 16'h0006);
    assign grp_hit[3] = (dec_instr[15:6] == 10'h037);
    assign grp_hit[4] = (dec_instr[15:9] == 7'h3a) || (dec_instr[15:9] == 7'h3b);
    assign grp_hit[5] = (dec_instr[15:9] == 7'h38);
    assign grp_hit[6] = (dec_instr[15:9] == 7'h39);
    assign grp_hit[7] = (dec_instr[15:9] == 7'h3c);
    assign grp_hit[8] = (dec_instr[15:9] == 7'h3d);
    assign grp_hit[9] = (dec_instr == 16'h0007);
    assign grp_hit[10] = (dec_instr[14:6] == 9'h035) || (dec_instr[14:6] == 9'h036);
    assign grp_hit[11] = (dec_instr[15:3] == 13'h0013);
    assign grp_hit[12] = (dec_instr[15:6] == 10'h038);
    wire grp_refused = |(grp_hit & ~(GROUP_EN & ctrl_groups)); // see RULE8

    wire same_reg = is_double && (s_mode == 3'd0) && (s_reg == d_reg);
    wire auto_dst = (d_mode == 3'd2) || (d_mode == 3'd4);
    wire def_dst = (d_mode == 3'd3) || (d_mode == 3'd5);
    wire jump_any = is_jump | is_call;
    wire short_fatal = (RST_VARIANT == `ISV_RST_SHORT) && is_reset && pf_level;

    // Reset sequencer hookup
    wire seq_init, seq_busy, seq_done, seq_trap, seq_late;
    wire seq_start = dec_valid && is_reset && !reset_busy && !short_fatal;
    isv_reset_seq #(
        .VARIANT(RST_VARIANT),
        .TOTAL_CYC(SEQ_TOTAL),
        .INIT_CYC(SEQ_INIT),
        .MIN_CYC(SEQ_MIN)
    ) u_seq (
        .clk_sys(clk_sys),
        .rst(rst),
        .start(seq_start),
        .pf_rise(pf_rise),
        .init(seq_init),
        .busy(seq_busy),
        .done(seq_done),
        .pf_trap(seq_trap),
        .pf_late(seq_late)
    );

    // Decode stage: one registered answer per accepted instruction
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            dec_done <= 1'b0;
            src_override <= 1'b0;
            src_value <= 16'h0000;
            pc_store <= 1'b0;
            pc_store_value <= 16'h0000;
            jump_valid <= 1'b0;
            jump_pc <= 16'h0000;
            trap_req <= 1'b0;
            trap_vec <= 8'h00;
            v_clear <= 1'b0;
        end else begin
            dec_done <= dec_valid;
            src_override <= 1'b0;
            pc_store <= 1'b0;
            jump_valid <= 1'b0;
            trap_req <= 1'b0;
            v_clear <= 1'b0;
            if (dec_valid) begin
                if (same_reg && auto_dst) begin
                    src_override <= 1'b1;
                    src_value <= SAME_REG_STEPPED ? stepped(dec_reg, d_mode) : dec_reg; // see RULE1
                end
                if (same_reg && def_dst) begin
                    src_override <= 1'b1;
                    src_value <= DEF_REG_STEPPED ? stepped(dec_reg, d_mode) : dec_reg; // see RULE2
                end
                // Index, index deferred, relative (modes 6, 7) and absolute (@# through PC)
                if (is_double && s_mode == 3'd0 && s_reg == 3'd7 &&
                    (d_mode[2:1] == 2'b11 || (d_mode == 3'd3 && d_reg == 3'd7))) begin
                    pc_store <= 1'b1;
                    pc_store_value <= dec_pc + (PC_STORE_PLUS4 ? 16'h0004 : 16'h0002); // see RULE3
                end
                if (jump_any && d_mode == 3'd2) begin
                    jump_valid <= 1'b1;
                    jump_pc <= JUMP_AUTOINC_STEPPED ? stepped(dec_reg, d_mode) : dec_reg; // see RULE4
                end
                if (jump_any && d_mode == 3'd0) begin
                    trap_req <= 1'b1;
                    trap_vec <= JUMP_REG_VEC4 ? `ISV_VEC_BUSERR : `ISV_VEC_ILLEGAL; // see RULE5
                end else if (grp_refused) begin
                    trap_req <= 1'b1;
                    trap_vec <= `ISV_VEC_ILLEGAL; // see RULE8
                end
                if (is_byte_swap_op)
                    v_clear <= BYTE_SWAP_OP_CLEARS_V; // see RULE6
            end
        end
    end

    // Register-window access check
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            acc_timeout <= 1'b0;
        end else begin
            acc_timeout <= 1'b0;
            if (acc_valid && in_window(acc_addr)) begin
                case (WIN_MODE)
                    `ISV_WIN_CPU_TMO: acc_timeout <= !acc_console; // see RULE7
                    `ISV_WIN_ALL_TMO: acc_timeout <= 1'b1; // see RULE7
                    default: acc_timeout <= 1'b0;
                endcase
            end
        end
    end

    // Reset and power-fail outputs
    wire pf_now = pf_rise && (!seq_busy || RST_VARIANT != `ISV_RST_LONG); // see RULE9
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            bus_init <= 1'b0;
            reset_busy <= 1'b0;
            pf_ack <= 1'b0;
            pf_fatal <= 1'b0;
        end else begin
            bus_init <= seq_init;
            reset_busy <= seq_busy | seq_start;
            pf_ack <= (pf_now | seq_late) & ~short_fatal;
            pf_fatal <= dec_valid & short_fatal; // see RULE11
        end
    end

    // Event collection for the status register
    always @* begin
        events = {`ISV_EV_W{1'b0}};
        events[`ISV_EV_ILL_JUMP] = dec_valid && jump_any && d_mode == 3'd0;
        events[`ISV_EV_RSVD_OP] = dec_valid && grp_refused && !(jump_any && d_mode == 3'd0);
        events[`ISV_EV_WIN_TMO] = acc_timeout;
        events[`ISV_EV_RST_DONE] = seq_done;
        events[`ISV_EV_PF_TRAP] = seq_trap;
        events[`ISV_EV_PF_FATAL] = pf_fatal;
        events[`ISV_EV_PF_ACK] = pf_ack;
    end

    // Wishbone slave: one wait state, ack held for one cycle
    wire wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    // Writes land at the edge at which the master sees ack
    wire wb_wr = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i;
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
            ctrl_groups <= `ISV_CTRL_RESET;
            mask <= {`ISV_EV_W{1'b0}};
            status <= {`ISV_EV_W{1'b0}};
            last_vec <= 8'h00;
            irq <= 1'b0;
        end else begin
            wb_ack_o <= wb_req;
            if (trap_req)
                last_vec <= trap_vec;
            // Set wins over a write-one clear in the same cycle
            if (wb_wr && wb_adr_i == `ISV_REG_STATUS && wb_sel_i[0])
                status <= (status & ~wb_dat_i[`ISV_EV_W-1:0]) | events;
            else
                status <= status | events;
            if (wb_wr && wb_adr_i == `ISV_REG_CTRL) begin
                if (wb_sel_i[0])
                    ctrl_groups[7:0] <= wb_dat_i[7:0];
                if (wb_sel_i[1])
                    ctrl_groups[12:8] <= wb_dat_i[12:8];
            end
            if (wb_wr && wb_adr_i == `ISV_REG_MASK && wb_sel_i[0])
                mask <= wb_dat_i[`ISV_EV_W-1:0];
            irq <= |(status & mask);
            if (wb_req && !wb_we_i) begin
                case (wb_adr_i)
                    `ISV_REG_CTRL: wb_dat_o <= {19'h00000, ctrl_groups};
                    `ISV_REG_STATUS: wb_dat_o <= {25'h0000000, status};
                    `ISV_REG_MASK: wb_dat_o <= {25'h0000000, mask};
                    `ISV_REG_STATE: wb_dat_o <= {20'h00000, last_vec, pf_level,
                        seq_init, seq_busy, irq};
                    `ISV_REG_CONFIG: wb_dat_o <= {9'h000, RST_VARIANT, GROUP_EN, WIN_MODE,
                        BYTE_SWAP_OP_CLEARS_V, JUMP_REG_VEC4, JUMP_AUTOINC_STEPPED,
                        PC_STORE_PLUS4, DEF_REG_STEPPED, SAME_REG_STEPPED};
                    default: wb_dat_o <= 32'h00000000;
                endcase
            end
        end
    end
endmodule // isv_decoder

// *** testbench/isv_decoder_sva.sv ***
// Port-level assertions for the variant decoder
`timescale 1ns/10ps
module isv_decoder_sva #(
    parameter [0:0] SAME_REG_STEPPED = 1'b1,
    parameter [0:0] JUMP_REG_VEC4 = 1'b0,
    parameter [1:0] WIN_MODE = 2'h1,
    parameter [1:0] RST_VARIANT = 2'h0
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic dec_valid,
    input wire logic [15:0] dec_instr,
    input wire logic [15:0] dec_reg,
    input wire logic dec_done,
    input wire logic src_override,
    input wire logic [15:0] src_value,
    input wire logic trap_req,
    input wire logic [7:0] trap_vec,
    input wire logic acc_valid,
    input wire logic acc_console,
    input wire logic [15:0] acc_addr,
    input wire logic acc_timeout,
    input wire logic reset_busy,
    input wire logic pf_ack
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    // Access inside the register window
    wire logic win = acc_valid && acc_addr >= 16'hffc0 && acc_addr <= 16'hffcf;
    // Decode steps
    sequence s_rst_req;
        dec_valid && dec_instr == 16'h0005 && !reset_busy;
    endsequence
    sequence s_same_reg;
        dec_valid && dec_instr[15:9] == 7'h08 && dec_instr[5:3] == 3'h2
            && dec_instr[8:6] == dec_instr[2:0];
    endsequence
    sequence s_jmp_reg;
        dec_valid && dec_instr[5:3] == 3'h0
            && (dec_instr[15:6] == 10'h001 || dec_instr[15:9] == 7'h04);
    endsequence
    property p_dec_done;
        dec_valid |=> dec_done;
    endproperty
    a_dec_done: assert property (p_dec_done) else $error("decode not answered");
    property p_dec_idle;
        !dec_valid |=> !dec_done;
    endproperty
    a_dec_idle: assert property (p_dec_idle) else $error("spurious done");
    property p_same_reg;
        s_same_reg |=> src_override
            && src_value == $past(dec_reg) + (SAME_REG_STEPPED ? 16'h0002 : 16'h0000);
    endproperty
    a_same_reg: assert property (p_same_reg) else $error("bad source value");
    property p_jmp_reg;
        s_jmp_reg |=> trap_req && trap_vec == (JUMP_REG_VEC4 ? 8'h04 : 8'h08);
    endproperty
    a_jmp_reg: assert property (p_jmp_reg) else $error("bad jump trap");
    property p_win;
        win |=> acc_timeout == (WIN_MODE == 2'h2 || (WIN_MODE == 2'h1 && !$past(acc_console)));
    endproperty
    a_win: assert property (p_win) else $error("bad window timeout");
    property p_win_miss;
        !win |=> !acc_timeout;
    endproperty
    a_win_miss: assert property (p_win_miss) else $error("timeout outside window");
    property p_rst_start;
        s_rst_req |=> reset_busy;
    endproperty
    a_rst_start: assert property (p_rst_start) else $error("reset not started");
    property p_pf_hold;
        pf_ack && RST_VARIANT == 2'h0 |-> !reset_busy;
    endproperty
    a_pf_hold: assert property (p_pf_hold) else $error("power fail seen in reset");
    property p_wb_ack;
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
    endproperty
    a_wb_ack: assert property (p_wb_ack) else $error("bus not acknowledged");
    property p_wb_drop;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_wb_drop: assert property (p_wb_drop) else $error("ack held too long");
endmodule // isv_decoder_sva

bind isv_decoder isv_decoder_sva #(.SAME_REG_STEPPED(SAME_REG_STEPPED),
    .JUMP_REG_VEC4(JUMP_REG_VEC4), .WIN_MODE(WIN_MODE), .RST_VARIANT(RST_VARIANT)) u_sva (
    .clk_sys(clk_sys), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_ack_o(wb_ack_o), .dec_valid(dec_valid), .dec_instr(dec_instr), .dec_reg(dec_reg),
    .dec_done(dec_done), .src_override(src_override), .src_value(src_value),
    .trap_req(trap_req), .trap_vec(trap_vec), .acc_valid(acc_valid),
    .acc_console(acc_console), .acc_addr(acc_addr), .acc_timeout(acc_timeout),
    .reset_busy(reset_busy), .pf_ack(pf_ack));

// *** testbench/tb_top.sv ***
// Self-checking bench for the variant decoder
`timescale 1ns/10ps
`include "isv_defs.vh"
module tb_top;
    localparam [0:0] SAME = 1'b0, DEF = 1'b1, PLUS4 = 1'b0, JSTEP = 1'b1, VEC4 = 1'b1;
    logic clk_sys = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic dv = 1'b0, av = 1'b0, acon = 1'b0, pf = 1'b0;
    logic [4:0] adr = 5'h00;
    logic [31:0] wdat = 32'h0, rd;
    logic [15:0] ins = 16'h0, pc = 16'h0, rg = 16'h0, aadr = 16'h0, v, p;
    logic [15:0] gop [13] = '{16'h7e41, 16'h0d01, 16'h0006, 16'h0dc1, 16'h7441, 16'h7041,
        16'h7241, 16'h7841, 16'h7a01, 16'h0007, 16'h0d41, 16'h0099, 16'h0e01};
    logic [5:0] pcd [5] = '{6'h37, 6'h3f, 6'h1f, 6'h31, 6'h39};
    logic [15:0] wad [5] = '{16'hffc0, 16'hffcf, 16'hffc7, 16'hffbf, 16'hffd0};
    wire [31:0] wb_dat_o;
    wire [15:0] src_value, pc_store_value, jump_pc;
    wire [7:0] trap_vec;
    wire wb_ack_o, dec_done, src_override, pc_store, jump_valid, trap_req, v_clear;
    wire acc_timeout, bus_init, reset_busy, pf_ack, pf_fatal, irq;
    integer n_fail = 0, n_compared = 0, cycles = 0, seed = 32'h85eed46e;
    integer i, k, m, r, nb, ni, np;

    isv_decoder #(.SAME_REG_STEPPED(SAME), .DEF_REG_STEPPED(DEF), .PC_STORE_PLUS4(PLUS4),
        .JUMP_AUTOINC_STEPPED(JSTEP), .JUMP_REG_VEC4(VEC4), .BYTE_SWAP_OP_CLEARS_V(1'b1),
        .LONG_RST_CYC(24'd700), .LONG_INIT_CYC(24'd200), .SHORT_RST_CYC(24'd220)) dut (
        .clk_sys(clk_sys), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .dec_valid(dv), .dec_instr(ins), .dec_pc(pc), .dec_reg(rg),
        .acc_valid(av), .acc_console(acon), .acc_addr(aadr), .power_fail(pf),
        .dec_done(dec_done), .src_override(src_override), .src_value(src_value),
        .pc_store(pc_store), .pc_store_value(pc_store_value), .jump_valid(jump_valid),
        .jump_pc(jump_pc), .trap_req(trap_req), .trap_vec(trap_vec), .v_clear(v_clear),
        .acc_timeout(acc_timeout), .bus_init(bus_init), .reset_busy(reset_busy),
        .pf_ack(pf_ack), .pf_fatal(pf_fatal), .irq(irq));

    // Clock and hang guard
    always #5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        cycles = cycles + 1;
        if (cycles == 20000) begin
            n_fail = n_fail + 1;
            final_report;
        end
    end

    task final_report;
        $display("compared %0d, mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared = n_compared + 1;
        if (got !== exp) begin
            n_fail = n_fail + 1;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One classic Wishbone cycle, held until ack
    task wb(input logic w, input logic [4:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clk_sys);
        end while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    // One decode request, outputs looked at in the answer cycle
    task dec(input logic [15:0] i, input logic [15:0] a, input logic [15:0] r);
        @(posedge clk_sys);
        dv <= 1'b1;
        ins <= i;
        pc <= a;
        rg <= r;
        @(posedge clk_sys);
        dv <= 1'b0;
        #1;
        chk(dec_done, 1'b1);
    endtask

    initial begin
        repeat (20) @(posedge clk_sys);
        rst <= 1'b0;
        wb(1'b0, `ISV_REG_CTRL, 32'h0); chk(rd, 32'h1fff);
        wb(1'b0, `ISV_REG_MASK, 32'h0); chk(rd, 32'h0);
        wb(1'b0, 5'h14, 32'h0); chk(rd, 32'h0);
        wb(1'b0, `ISV_REG_CONFIG, 32'h0);
        chk(rd, {9'h0, 2'h0, 13'h1fff, 2'h1, 1'b1, VEC4, JSTEP, PLUS4, DEF, SAME});
        // Same-register source with stepped destinations
        for (m = 2; m < 6; m = m + 1) begin
            r = $unsigned($random(seed)) % 6;
            v = $random(seed) & 16'hfffe;
            p = (m == 2 || m == 4) ? SAME : DEF;
            dec({4'h1, 3'h0, r[2:0], m[2:0], r[2:0]}, 16'h1000, v);
            chk({src_override, src_value}, {1'b1, p ? v + ((m < 4) ? 16'h0002 : 16'hfffe) : v});
        end
        // Program counter as source
        for (k = 0; k < 5; k = k + 1) begin
            p = $random(seed) & 16'hfffe;
            dec({4'h1, 3'h0, 3'h7, pcd[k]}, p, 16'h0);
            chk({pc_store, pc_store_value}, {1'b1, p + (PLUS4 ? 16'h0004 : 16'h0002)});
        end
        // Jump and call through autoincrement, then register-mode traps
        wb(1'b1, `ISV_REG_MASK, 32'h01);
        for (k = 0; k < 4; k = k + 1) begin
            v = $random(seed) & 16'hfffe;
            m = (k < 2) ? 2 : 0;
            dec(k[0] ? {7'h04, 3'h5, m[2:0], 3'h1} : {10'h001, m[2:0], 3'h1}, 16'h2000, v);
            if (k < 2)
                chk({jump_valid, jump_pc}, {1'b1, JSTEP ? v + 16'h0002 : v});
            else
                chk({trap_req, trap_vec}, {1'b1, VEC4 ? 8'h04 : 8'h08});
        end
        repeat (2) @(posedge clk_sys);
        #1 chk(irq, 1'b1);
        wb(1'b1, `ISV_REG_STATUS, 32'h01);
        repeat (2) @(posedge clk_sys);
        #1 chk(irq, 1'b0);
        dec(16'h00c1, 16'h3000, 16'h0); chk(v_clear, 1'b1);
        // Register window accesses, CPU and console
        for (k = 0; k < 5; k = k + 1) begin
            @(posedge clk_sys);
            av <= 1'b1;
            aadr <= wad[k];
            acon <= (k == 2);
            @(posedge clk_sys);
            av <= 1'b0;
            #1 chk(acc_timeout, k < 2);
        end
        wb(1'b1, `ISV_REG_STATUS, 32'h7f);
        // Each optional group, disabled then enabled
        for (k = 0; k < 13; k = k + 1) begin
            wb(1'b1, `ISV_REG_CTRL, 32'h1fff ^ (32'h1 << k));
            dec(gop[k], 16'h4000, 16'h0100); chk({trap_req, trap_vec}, 9'h108);
            wb(1'b1, `ISV_REG_CTRL, 32'h1fff);
            dec(gop[k], 16'h4000, 16'h0100); chk(trap_req, 1'b0);
        end
        wb(1'b0, `ISV_REG_STATUS, 32'h0); chk(rd, 32'h02);
        wb(1'b1, `ISV_REG_STATUS, 32'h02);
        // Long bus reset with a power failure part way through
        dec(16'h0005, 16'h5000, 16'h0);
        nb = reset_busy;
        ni = bus_init;
        np = 0;
        for (i = 0; i < 1000; i = i + 1) begin
            @(posedge clk_sys);
            if (i == 300)
                pf <= 1'b1;
            #1;
            nb = nb + reset_busy;
            ni = ni + bus_init;
            np = np + pf_ack + 2 * pf_fatal;
        end
        chk(nb, 700);
        chk(ni, 200);
        chk(np, 1);
        wb(1'b0, `ISV_REG_STATUS, 32'h0); chk(rd, 32'h48);
        pf <= 1'b0;
        final_report;
    end
endmodule // tb_top
